// >>> rbs_pkg.sv
// Purpose: Shared constants and types of the reset and boot sequencer
// Assumes: One core clock at 250 MHz
// Notes:   Slave register subaddresses are byte wide
package rbs_pkg;

   // Core clock and long timing figures
   localparam int RBS_CLK_MHZ        = 250;
   localparam int RBS_TEST_LOAD_MS   = 100;
   localparam int RBS_TEST_LOAD_CYC  = RBS_TEST_LOAD_MS * 1000 * RBS_CLK_MHZ;
   localparam int RBS_LOAD_CNT_W     = 25;

   // Housekeeping: memory clear and default register load
   localparam int RBS_MEM_WORDS      = 1024;
   localparam int RBS_DEFLOAD_CYC    = 16;

   // Two-wire addresses; base values are arbitrary
   localparam logic [6:0] RBS_SLAVE_ADDR_BASE  = 7'h34;
   localparam logic [6:0] RBS_MASTER_ADDR_BASE = 7'h50;

   // Slave port register subaddresses
   localparam logic [7:0] RBS_LOAD_STATUS_ADDR = 8'h02;
   localparam logic [7:0] RBS_GPIO_CTRL_ADDR   = 8'h03;

   // Load status field positions
   localparam int RBS_ST_LOADED   = 0;
   localparam int RBS_ST_NO_MEM   = 1;
   localparam int RBS_ST_MEM_ERR  = 2;
   localparam int RBS_ST_TEST     = 3;
   localparam int RBS_ST_DONE     = 4;
   localparam int RBS_ST_PIN      = 8;

   // Pin control field positions and reset value
   localparam int RBS_GC_DIR_OUT  = 0;
   localparam int RBS_GC_VALUE    = 1;
   localparam int RBS_GC_PROGRAM  = 2;
   localparam logic [7:0] RBS_GC_RESET = 8'h00;

   // Sequencer states
   typedef enum logic [3:0] {
      RBS_HOUSEKEEP,
      RBS_LOAD_DEFAULTS,
      RBS_SEARCH,
      RBS_WAIT_TEST,
      RBS_STATUS_UPD,
      RBS_SLAVE_EN,
      RBS_PIN_DRIVE,
      RBS_RUN
   } rbs_seq_t;

   // Two-wire slave states
   typedef enum logic [3:0] {
      RBS_TW_IDLE,
      RBS_TW_ADDR,
      RBS_TW_ADDR_ACK,
      RBS_TW_SUB,
      RBS_TW_SUB_ACK,
      RBS_TW_WDATA,
      RBS_TW_WACK,
      RBS_TW_RDATA,
      RBS_TW_RACK,
      RBS_TW_RNEXT
   } rbs_tw_t;

endpackage : rbs_pkg

// >>> rbs_twi_slave.sv
// Purpose: Two-wire slave giving register access by subaddress
// Assumes: Line inputs already synchronised to core_clk
// Notes:   Never stretches the clock; reads send 4 bytes MSB first
`timescale 1ns/1ps
`default_nettype none
module rbs_twi_slave (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       enable,
   // Synchronised lines
   input  wire logic       scl,
   input  wire logic       sda,
   // Address and register access
   input  wire logic [6:0] dev_addr,
   input  wire logic [31:0] rd_data,
   output logic            sda_pull,
   output logic [7:0]      reg_addr,
   output logic            wr_strobe,
   output logic [7:0]      wr_data
);

   rbs_pkg::rbs_tw_t state;
   logic             scl_q;
   logic             sda_q;
   logic [7:0]       shift;
   logic [3:0]       bit_cnt;
   logic             rd_mode;
   logic [1:0]       byte_idx;

   function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                            input logic [1:0] i);
      pick_byte = w[8 * (3 - i) +: 8];
   endfunction : pick_byte

   wire logic scl_rise  = scl & ~scl_q;
   wire logic scl_fall  = ~scl & scl_q;
   wire logic start_seen = scl & scl_q & sda_q & ~sda;
   wire logic stop_seen  = scl & scl_q & ~sda_q & sda;
   wire logic byte_in   = scl_fall & (bit_cnt == 4'h8);
   wire logic [7:0] next_rd = pick_byte(rd_data, byte_idx);

   always_ff @(posedge core_clk) begin
      if (!nrst || !enable) begin
         state     <= rbs_pkg::RBS_TW_IDLE;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
         shift     <= 8'h00;
         bit_cnt   <= 4'h0;
         rd_mode   <= 1'b0;
         byte_idx  <= 2'h0;
         sda_pull  <= 1'b0;
         reg_addr  <= 8'h00;
         wr_strobe <= 1'b0;
         wr_data   <= 8'h00;
      end else begin
         scl_q     <= scl;
         sda_q     <= sda;
         wr_strobe <= 1'b0;
         if (start_seen) begin
            state    <= rbs_pkg::RBS_TW_ADDR;
            bit_cnt  <= 4'h0;
            sda_pull <= 1'b0;
         end else if (stop_seen) begin
            state    <= rbs_pkg::RBS_TW_IDLE;
            sda_pull <= 1'b0;
         end else begin
            unique case (state)
               rbs_pkg::RBS_TW_IDLE: begin
               end
               rbs_pkg::RBS_TW_ADDR, rbs_pkg::RBS_TW_SUB,
               rbs_pkg::RBS_TW_WDATA: begin
                  if (scl_rise) begin
                     shift   <= {shift[6:0], sda};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (byte_in) begin
                     bit_cnt <= 4'h0;
                     if (state == rbs_pkg::RBS_TW_ADDR) begin
                        // Foreign addresses are left alone
                        if (shift[7:1] == dev_addr) begin
                           sda_pull <= 1'b1;
                           rd_mode  <= shift[0];
                           state    <= rbs_pkg::RBS_TW_ADDR_ACK;
                        end else begin
                           state <= rbs_pkg::RBS_TW_IDLE;
                        end
                     end else if (state == rbs_pkg::RBS_TW_SUB) begin
                        reg_addr <= shift;
                        byte_idx <= 2'h0;
                        sda_pull <= 1'b1;
                        state    <= rbs_pkg::RBS_TW_SUB_ACK;
                     end else begin
                        wr_strobe <= 1'b1;
                        wr_data   <= shift;
                        sda_pull  <= 1'b1;
                        state     <= rbs_pkg::RBS_TW_WACK;
                     end
                  end
               end
               rbs_pkg::RBS_TW_ADDR_ACK: begin
                  if (scl_fall) begin
                     if (rd_mode) begin
                        shift    <= pick_byte(rd_data, 2'h0);
                        byte_idx <= 2'h1;
                        sda_pull <= ~rd_data[31];
                        state    <= rbs_pkg::RBS_TW_RDATA;
                     end else begin
                        sda_pull <= 1'b0;
                        state    <= rbs_pkg::RBS_TW_SUB;
                     end
                  end
               end
               rbs_pkg::RBS_TW_SUB_ACK, rbs_pkg::RBS_TW_WACK: begin
                  if (scl_fall) begin
                     sda_pull <= 1'b0;
                     state    <= rbs_pkg::RBS_TW_WDATA;
                  end
               end
               rbs_pkg::RBS_TW_RDATA: begin
                  if (scl_fall) begin
                     if (bit_cnt == 4'h7) begin
                        bit_cnt  <= 4'h0;
                        sda_pull <= 1'b0;
                        state    <= rbs_pkg::RBS_TW_RACK;
                     end else begin
                        bit_cnt  <= bit_cnt + 4'h1;
                        shift    <= {shift[6:0], 1'b0};
                        sda_pull <= ~shift[6];
                     end
                  end
               end
               rbs_pkg::RBS_TW_RACK: begin
                  if (scl_rise) begin
                     state <= sda ? rbs_pkg::RBS_TW_IDLE
                                  : rbs_pkg::RBS_TW_RNEXT;
                  end
               end
               rbs_pkg::RBS_TW_RNEXT: begin
                  if (scl_fall) begin
                     shift    <= next_rd;
                     byte_idx <= byte_idx + 2'h1;
                     sda_pull <= ~next_rd[7];
                     state    <= rbs_pkg::RBS_TW_RDATA;
                  end
               end
               default: begin
                  state <= rbs_pkg::RBS_TW_IDLE;
               end
            endcase
         end
      end
   end

endmodule : rbs_twi_slave
`default_nettype wire

// >>> rbs_sequencer.sv
// Purpose: Reset, power-down and boot initialization sequencer
// Assumes: Boot memory search run by a master-port engine on core_clk
// Notes:   Pins pass two flops; open-drain lines only ever pull low
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer #(
   parameter int unsigned TEST_LOAD_CYC = rbs_pkg::RBS_TEST_LOAD_CYC
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       nrst,
   // Control pins
   input  wire logic       power_down_n,
   input  wire logic       address_select,
   // General purpose pin
   input  wire logic       gpio_in,
   output logic            gpio_out,
   output logic            gpio_oe,
   // Slave two-wire port
   input  wire logic       slave_port_clock_in,
   output logic            slave_port_clock_out,
   output logic            slave_port_clock_oe,
   input  wire logic       slave_port_data_in,
   output logic            slave_port_data_out,
   output logic            slave_port_data_oe,
   // Master two-wire port
   input  wire logic       master_clock_pull,
   input  wire logic       master_data_pull,
   output logic            master_port_clock_out,
   output logic            master_port_clock_oe,
   output logic            master_port_data_out,
   output logic            master_port_data_oe,
   output logic [6:0]      master_addr,
   // Boot memory search
   output logic            boot_search_req,
   input  wire logic       boot_answer,
   input  wire logic       boot_found,
   input  wire logic       boot_error,
   // Serial audio
   input  wire logic [3:0] serial_in,
   input  wire logic [3:0] core_serial_out,
   output logic [3:0]      serial_out,
   // Core and housekeeping
   output logic            core_idle,
   output logic            clocks_enable,
   output logic            mem_clear_we,
   output logic [9:0]      mem_clear_addr,
   output logic            default_load
);

   rbs_pkg::rbs_seq_t state;
   logic [8:0]  sync_a;
   logic [8:0]  sync_b;
   logic [9:0]  hk_cnt;
   logic [rbs_pkg::RBS_LOAD_CNT_W-1:0] since_rst;
   logic        test_mode;
   logic        loaded;
   logic        no_mem;
   logic        mem_err;
   logic        init_done;
   logic        slave_en;
   logic        master_en;
   logic        programmed;
   logic        pin_drive;
   logic [7:0]  gpio_ctrl;
   logic        tw_pull;
   logic [7:0]  tw_addr;
   logic        tw_wr;
   logic [7:0]  tw_data;

   // Synchronised pins
   wire logic       pd_n_s   = sync_b[0];
   wire logic       sel_s    = sync_b[1];
   wire logic       gpio_s   = sync_b[2];
   wire logic       scl_s    = sync_b[3];
   wire logic       sda_s    = sync_b[4];
   wire logic [3:0] sin_s    = sync_b[8:5];
   wire logic       run      = pd_n_s;

   wire logic [31:0] status_word = {23'h00_0000, gpio_s, 3'h0, init_done,
                                    test_mode, mem_err, no_mem, loaded};
   wire logic [31:0] rd_word =
      (tw_addr == rbs_pkg::RBS_LOAD_STATUS_ADDR) ? status_word :
      (tw_addr == rbs_pkg::RBS_GPIO_CTRL_ADDR) ? {24'h00_0000, gpio_ctrl} :
      32'h0000_0000;
   wire logic [6:0] slave_addr = rbs_pkg::RBS_SLAVE_ADDR_BASE | {6'h00, sel_s};
   wire logic       gc_wr = tw_wr & (tw_addr == rbs_pkg::RBS_GPIO_CTRL_ADDR);
   wire logic       hk_last = hk_cnt == 10'(rbs_pkg::RBS_MEM_WORDS - 1);
   wire logic       dl_last = hk_cnt == 10'(rbs_pkg::RBS_DEFLOAD_CYC - 1);
   wire logic       test_due =
      since_rst >= rbs_pkg::RBS_LOAD_CNT_W'(TEST_LOAD_CYC - 1);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sync_a <= 9'h000;
         sync_b <= 9'h000;
      end else begin
         sync_a <= {serial_in, slave_port_data_in, slave_port_clock_in,
                    gpio_in, address_select, power_down_n};
         sync_b <= sync_a;
      end
   end

   rbs_twi_slave u_slave (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .enable    (slave_en),
      .scl       (scl_s),
      .sda       (sda_s),
      .dev_addr  (slave_addr),
      .rd_data   (rd_word),
      .sda_pull  (tw_pull),
      .reg_addr  (tw_addr),
      .wr_strobe (tw_wr),
      .wr_data   (tw_data)
   );

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         since_rst <= '0;
      end else if (run && !test_due) begin
         since_rst <= since_rst + 1'b1;
      end
   end

   // Reset returns every flag to default
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state      <= rbs_pkg::RBS_HOUSEKEEP;
         hk_cnt     <= 10'h000;
         test_mode  <= 1'b0;
         loaded     <= 1'b0;
         no_mem     <= 1'b0;
         mem_err    <= 1'b0;
         init_done  <= 1'b0;
         slave_en   <= 1'b0;
         master_en  <= 1'b0;
         pin_drive  <= 1'b0;
      end else if (run) begin
         unique case (state)
            rbs_pkg::RBS_HOUSEKEEP: begin
               hk_cnt <= hk_last ? 10'h000 : hk_cnt + 10'h001;
               if (hk_last) begin
                  state <= rbs_pkg::RBS_LOAD_DEFAULTS;
               end
            end
            rbs_pkg::RBS_LOAD_DEFAULTS: begin
               hk_cnt <= dl_last ? 10'h000 : hk_cnt + 10'h001;
               if (dl_last) begin
                  master_en <= 1'b1;
                  state     <= rbs_pkg::RBS_SEARCH;
               end
            end
            rbs_pkg::RBS_SEARCH: begin
               if (boot_answer) begin
                  no_mem  <= ~boot_found;
                  mem_err <= boot_found & boot_error;
                  if (boot_found && !boot_error) begin
                     loaded <= 1'b1;
                     state  <= rbs_pkg::RBS_STATUS_UPD;
                  end else if (gpio_s) begin
                     state <= rbs_pkg::RBS_STATUS_UPD;
                  end else begin
                     test_mode <= 1'b1;
                     state     <= rbs_pkg::RBS_WAIT_TEST;
                  end
               end
            end
            rbs_pkg::RBS_WAIT_TEST: begin
               if (test_due) begin
                  state <= rbs_pkg::RBS_STATUS_UPD;
               end
            end
            rbs_pkg::RBS_STATUS_UPD: begin
               init_done <= 1'b1;
               state     <= rbs_pkg::RBS_SLAVE_EN;
            end
            rbs_pkg::RBS_SLAVE_EN: begin
               slave_en <= 1'b1;
               state    <= loaded ? rbs_pkg::RBS_RUN
                                  : rbs_pkg::RBS_PIN_DRIVE;
            end
            rbs_pkg::RBS_PIN_DRIVE: begin
               pin_drive <= 1'b1;
               state     <= rbs_pkg::RBS_RUN;
            end
            rbs_pkg::RBS_RUN: begin
            end
            default: begin
               state <= rbs_pkg::RBS_HOUSEKEEP;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         gpio_ctrl  <= rbs_pkg::RBS_GC_RESET;
         programmed <= 1'b0;
      end else begin
         if (gc_wr) begin
            gpio_ctrl <= tw_data;
         end
         programmed <= programmed | loaded
                       | (gc_wr & tw_data[rbs_pkg::RBS_GC_PROGRAM]);
      end
   end

   // Pin stays an input until programmed, or until pin drive low after an init without a load
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         gpio_oe  <= 1'b0;
         gpio_out <= 1'b0;
      end else if (programmed) begin
         gpio_oe  <= gpio_ctrl[rbs_pkg::RBS_GC_DIR_OUT];
         gpio_out <= gpio_ctrl[rbs_pkg::RBS_GC_VALUE];
      end else begin
         gpio_oe  <= pin_drive;
         gpio_out <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         slave_port_clock_out  <= 1'b0;
         slave_port_clock_oe   <= 1'b0;
         slave_port_data_out   <= 1'b0;
         slave_port_data_oe    <= 1'b0;
         master_port_clock_out <= 1'b0;
         master_port_clock_oe  <= 1'b0;
         master_port_data_out  <= 1'b0;
         master_port_data_oe   <= 1'b0;
         master_addr           <= rbs_pkg::RBS_MASTER_ADDR_BASE;
      end else begin
         slave_port_data_oe   <= tw_pull & slave_en;
         master_port_clock_oe <= master_clock_pull & master_en;
         master_port_data_oe  <= master_data_pull & master_en;
         master_addr <= rbs_pkg::RBS_MASTER_ADDR_BASE | {6'h00, sel_s};
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         serial_out      <= 4'h0;
         boot_search_req <= 1'b0;
         core_idle       <= 1'b1;
         clocks_enable   <= 1'b0;
         mem_clear_we    <= 1'b0;
         mem_clear_addr  <= 10'h000;
         default_load    <= 1'b0;
      end else begin
         serial_out <= (test_mode && init_done) ? sin_s :
                       (programmed ? core_serial_out : 4'h0);
         boot_search_req <= run & (state == rbs_pkg::RBS_SEARCH)
                            & ~boot_answer;
         core_idle     <= ~programmed;
         clocks_enable <= run;
         // No memory writes while powered down
         mem_clear_we   <= run & (state == rbs_pkg::RBS_HOUSEKEEP);
         mem_clear_addr <= hk_cnt;
         default_load   <= run & (state == rbs_pkg::RBS_LOAD_DEFAULTS);
      end
   end

endmodule : rbs_sequencer
`default_nettype wire

// >>> rbs_sequencer_properties.sv
// Purpose: Port assertions for the reset and boot sequencer
// Assumes: Bound into rbs_sequencer, one clock domain
// Notes:   Sync delays allowed for with margin
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer_properties #(
   parameter int unsigned TEST_LOAD_CYC = 2000
) (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       nrst,
   // Pins
   input wire logic       power_down_n,
   input wire logic       address_select,
   input wire logic       gpio_out,
   input wire logic       gpio_oe,
   input wire logic       slave_port_data_oe,
   input wire logic       master_port_data_oe,
   input wire logic [6:0] master_addr,
   // Boot search and core
   input wire logic       boot_search_req,
   input wire logic       boot_answer,
   input wire logic [3:0] serial_out,
   input wire logic       core_idle,
   input wire logic       clocks_enable,
   input wire logic       mem_clear_we,
   input wire logic [9:0] mem_clear_addr,
   input wire logic       default_load
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic searched;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         searched <= 1'b0;
      end else if (boot_answer && boot_search_req) begin
         searched <= 1'b1;
      end
   end
   sequence s_load16;
      default_load [*8] ##1 default_load [*8];
   endsequence
   chk_reset_quiet: assert property (
      $rose(nrst) |-> core_idle && !gpio_oe && !slave_port_data_oe
      && !master_port_data_oe && !boot_search_req && serial_out == 4'h0)
      else $error("outputs not quiet after reset");
   chk_slave_quiet: assert property (
      slave_port_data_oe |-> searched)
      else $error("slave answered before init");
   chk_clear_walk: assert property (
      mem_clear_we && mem_clear_addr != 10'h3FF |=> !mem_clear_we
      || mem_clear_addr == $past(mem_clear_addr) + 10'h001)
      else $error("memory clear walk skipped");
   chk_load_len: assert property (
      $rose(default_load) |-> s_load16 ##1 !default_load)
      else $error("default load length wrong");
   chk_search_drop: assert property (
      boot_search_req && boot_answer |=> !boot_search_req)
      else $error("search request held after answer");
   chk_addr_select: assert property (
      $stable(address_select) [*6] |-> master_addr == {6'h28, address_select})
      else $error("master address wrong");
   chk_pin_low: assert property (
      $rose(gpio_oe) && core_idle |-> !gpio_out)
      else $error("pin not driven low");
   chk_pd_stop: assert property (
      !power_down_n [*5] |-> !clocks_enable && !mem_clear_we)
      else $error("clocks run in power down");
   chk_pd_run: assert property (
      power_down_n [*6] |-> clocks_enable)
      else $error("clocks stopped while powered");
endmodule : rbs_sequencer_properties
bind rbs_sequencer rbs_sequencer_properties #(
   .TEST_LOAD_CYC(TEST_LOAD_CYC)) u_props (.*);
`default_nettype wire

// >>> rbs_boot_mem_model.sv
// Purpose: Boot memory answering the sequencer search
// Assumes: Same clock as the sequencer
// Notes:   Flags are junk outside the answer pulse
`timescale 1ns/1ps
`default_nettype none
module rbs_boot_mem_model #(
   parameter int DELAY = 64
) (
   input  wire logic core_clk,
   input  wire logic nrst,
   input  wire logic boot_search_req,
   input  wire logic present,
   input  wire logic bad_read,
   output logic      boot_answer,
   output logic      boot_found,
   output logic      boot_error
);
   int wait_cnt;
   always_ff @(posedge core_clk) begin
      if (!nrst || !boot_search_req || boot_answer) begin
         wait_cnt    <= 0;
         boot_answer <= 1'b0;
      end else begin
         wait_cnt    <= wait_cnt + 1;
         boot_answer <= (wait_cnt == DELAY);
      end
   end
   // Inverted off the pulse
   assign boot_found = boot_answer ? present : !present;
   assign boot_error = boot_answer ? bad_read : !bad_read;
endmodule : rbs_boot_mem_model
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the reset and boot sequencer
// Assumes: Boot memory model, bench acts as host
// Notes:   Short test load count keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int unsigned LOAD_CYC = 2000;
   logic core_clk, nrst, power_down_n, address_select, pin_ext;
   logic scl_drv, sda_drv, present, bad_read, ans, fnd, err, ack;
   logic gpio_out, gpio_oe, sd_oe, mc_oe, md_oe, req;
   logic core_idle, clk_en, we, dl;
   logic [3:0] serial_in, serial_out;
   logic [6:0] master_addr;
   logic [9:0] we_addr, a;
   logic [31:0] d;
   int         fail_count, n_checks, we_cnt, dl_cnt, n;
   wire        sda_line = sda_drv & ~sd_oe;
   wire        gpio_pin = gpio_oe ? gpio_out : pin_ext;
   rbs_sequencer #(.TEST_LOAD_CYC(LOAD_CYC)) uut (
      .core_clk(core_clk), .nrst(nrst), .power_down_n(power_down_n),
      .address_select(address_select), .gpio_in(gpio_pin),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .slave_port_clock_in(scl_drv), .slave_port_clock_out(),
      .slave_port_clock_oe(), .slave_port_data_in(sda_line),
      .slave_port_data_out(), .slave_port_data_oe(sd_oe),
      .master_clock_pull(1'b1), .master_data_pull(1'b1),
      .master_port_clock_out(), .master_port_clock_oe(mc_oe),
      .master_port_data_out(), .master_port_data_oe(md_oe),
      .master_addr(master_addr), .boot_search_req(req),
      .boot_answer(ans), .boot_found(fnd), .boot_error(err),
      .serial_in(serial_in), .core_serial_out(4'h0),
      .serial_out(serial_out), .core_idle(core_idle),
      .clocks_enable(clk_en), .mem_clear_we(we),
      .mem_clear_addr(we_addr), .default_load(dl));
   rbs_boot_mem_model boot_mem (.core_clk(core_clk), .nrst(nrst),
      .boot_search_req(req), .present(present), .bad_read(bad_read),
      .boot_answer(ans), .boot_found(fnd), .boot_error(err));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (we) we_cnt++;
      if (dl) dl_cnt++;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask : check
   task automatic wait_lvl(ref logic s, input logic v, input int lim,
                           output int n);
      n = 0;
      while (s !== v && n < lim) begin
         tick(1);
         n++;
      end
      if (n >= lim) check("wait bound", 32'h0000_0001, 32'h0000_0000);
   endtask : wait_lvl
   task automatic do_reset(input logic sel, input logic pin,
                           input logic mem, input logic bad);
      nrst = 1'b0;
      address_select = sel;
      pin_ext = pin;
      present = mem;
      bad_read = bad;
      serial_in = 4'hF;
      tick(10);
      check("reset outputs", 32'h0000_0020, {gpio_oe, sd_oe, mc_oe, md_oe,
            req, core_idle, clk_en, serial_out});
      we_cnt = 0;
      dl_cnt = 0;
      nrst = 1'b1;
   endtask : do_reset
   task automatic i2c_cond(input logic s);
      sda_drv = s;
      tick(8);
      scl_drv = 1'b1;
      tick(10);
      sda_drv = !s;
      tick(10);
      if (s) scl_drv = 1'b0;
      if (s) tick(2);
   endtask : i2c_cond
   task automatic i2c_byte(input logic [7:0] b, input logic nack,
                           output logic [7:0] r, output logic ack);
      for (int i = 0; i < 9; i++) begin
         sda_drv = (i == 8) ? nack : b[7 - i];
         tick(8);
         scl_drv = 1'b1;
         tick(10);
         if (i < 8) r[7 - i] = sda_line;
         else ack = sda_line;
         scl_drv = 1'b0;
         tick(2);
      end
   endtask : i2c_byte
   task automatic i2c_xfer(input logic [6:0] a, input logic [7:0] sub,
         input logic rd, input logic [7:0] wd, output logic [31:0] d,
         output logic ack);
      logic [7:0] r;
      logic       k;
      i2c_cond(1'b1);
      i2c_byte({a, 1'b0}, 1'b1, r, ack);
      i2c_byte(sub, 1'b1, r, k);
      if (rd) begin
         i2c_cond(1'b1);
         i2c_byte({a, 1'b1}, 1'b1, r, k);
         for (int j = 0; j < 4; j++) begin
            i2c_byte(8'hFF, j == 3, r, k);
            d = {d[23:0], r};
         end
      end else begin
         i2c_byte(wd, 1'b1, r, k);
      end
      i2c_cond(1'b0);
   endtask : i2c_xfer
   task automatic t_no_memory();
      do_reset(1'b0, 1'b1, 1'b0, 1'b0);
      i2c_xfer(7'h34, 8'h02, 1'b0, 8'h00, d, ack);
      check("early ack", 32'h0000_0001,
            {29'h0, mc_oe, md_oe, ack});
      wait_lvl(gpio_oe, 1'b1, 4000, n);
      check("clear count", 32'h0000_0400, we_cnt);
      check("load count", 32'h0000_0010, dl_cnt);
      check("master addr", 32'h0000_01D0, {23'h0, mc_oe, md_oe,
            master_addr});
      check("default pins", 32'h0000_0010, {gpio_out, core_idle,
            serial_out});
      i2c_xfer(7'h34, 8'h02, 1'b1, 8'h00, d, ack);
      check("status ack", 32'h0000_0000, {31'h0, ack});
      check("status", 32'h0000_0012, d);
   endtask : t_no_memory
   task automatic t_mem_error();
      do_reset(1'b1, 1'b1, 1'b1, 1'b1);
      wait_lvl(gpio_oe, 1'b1, 4000, n);
      check("selected addr", 32'h0000_0051, {25'h0, master_addr});
      i2c_xfer(7'h34, 8'h02, 1'b1, 8'h00, d, ack);
      check("other addr ack", 32'h0000_0001, {31'h0, ack});
      i2c_xfer(7'h35, 8'h02, 1'b1, 8'h00, d, ack);
      check("error status", 32'h0000_0014, d);
   endtask : t_mem_error
   task automatic t_test_mode();
      do_reset(1'b0, 1'b0, 1'b0, 1'b0);
      wait_lvl(gpio_oe, 1'b1, LOAD_CYC + 100, n);
      check("load time", 32'h0000_0001, {31'h0, n >= LOAD_CYC - 1
            && n <= LOAD_CYC + 16});
      check("test pin", 32'h0000_0000, {31'h0, gpio_out});
      for (int v = 0; v < 16; v += 5) begin
         serial_in = v[3:0];
         tick(4);
         check("pass through", v, {28'h0, serial_out});
      end
      i2c_xfer(7'h34, 8'h02, 1'b1, 8'h00, d, ack);
      check("test status", 32'h0000_001A, d);
   endtask : t_test_mode
   task automatic t_loaded();
      do_reset(1'b0, 1'b1, 1'b1, 1'b0);
      wait_lvl(core_idle, 1'b0, 3000, n);
      check("loaded pin", 32'h0000_0000, {31'h0, gpio_oe});
      i2c_xfer(7'h34, 8'h02, 1'b1, 8'h00, d, ack);
      check("loaded status", 32'h0000_0111, d);
      i2c_xfer(7'h34, 8'h03, 1'b0, 8'h03, d, ack);
      tick(4);
      check("pin program", 32'h0000_0003, {30'h0, gpio_oe, gpio_out});
   endtask : t_loaded
   task automatic t_power_down();
      do_reset(1'b0, 1'b1, 1'b0, 1'b0);
      tick(100);
      power_down_n = 1'b0;
      tick(10);
      a = we_addr;
      check("pd clocks", 32'h0000_0000, {30'h0, clk_en, we});
      tick(40);
      check("pd frozen", {22'h0, a}, {22'h0, we_addr});
      power_down_n = 1'b1;
      wait_lvl(gpio_oe, 1'b1, 4000, n);
      check("clear resumed", 32'h0000_0400, we_cnt);
   endtask : t_power_down
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict
   initial begin
      #200000;
      fail_count++;
      print_verdict();
   end
   initial begin
      {nrst, address_select, present, bad_read} = 4'h0;
      {power_down_n, pin_ext, scl_drv, sda_drv} = 4'hF;
      serial_in = 4'h0;
      fail_count = 0;
      n_checks = 0;
      t_no_memory();
      t_mem_error();
      t_test_mode();
      t_loaded();
      t_power_down();
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
